// ---- rtl/lock_pkg.sv ----
// constants for the program memory lock and verify encryption block
// assumes a 40 MHz pclk and a 32-bit apb master
// Operation
// - key bytes read erased until written
// - verify output is code xnor key, cycling
// - no lock bits, no restrictions, still encrypt except in the single-bit variant
// - level two blocks table reads, programming
// - level three also blocks verify
// - level four also blocks external execution in variant_three only
// - key array 32 or 64 bytes deep
// - erase clears keys and lock bits
// - external access pin latched at reset
// - single-bit variant blocks readout, program, external
// - single-bit erase unlocks and allows reprogram
package lock_pkg;
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_lock = 8'h04;
	localparam logic [7:0] addr_key = 8'h08;
	localparam logic [7:0] addr_verify = 8'h0c;
	localparam logic [7:0] addr_status = 8'h10;
	localparam logic [7:0] addr_variant = 8'h14;
	localparam int key_depth_small = 32;
	localparam int key_depth_large = 64;
	localparam logic [5:0] key_last_small = 6'h1f;
	localparam logic [5:0] key_last_large = 6'h3f;
	localparam logic [7:0] key_erased = 8'hff;
	localparam int ctrl_erase_bit = 0;
	localparam int ctrl_verify_start_bit = 1;
	localparam int ctrl_ext_exec_bit = 2;
	localparam int ctrl_table_ext_bit = 3;
	typedef enum logic [1:0] {
		variant_single = 2'b00,
		variant_two = 2'b01,
		variant_three = 2'b10
	} variant_type;
	typedef enum logic [1:0] {
		level_none = 2'b00,
		level_two = 2'b01,
		level_three = 2'b10,
		level_four = 2'b11
	} level_type;
	localparam variant_type variant_reset = variant_three;
endpackage

// ---- rtl/lock_decode.sv ----
// lock level decoder: lock bits and variant to restriction outputs
// assumes lock bits already held in flip-flops by the caller
`timescale 1ns/1ps
module lock_decode
(
	input wire logic [2:0] lock_bits,
	input wire lock_pkg::variant_type variant,
	output logic block_table_read,
	output logic block_program,
	output logic block_verify,
	output logic block_ext_exec,
	output logic latch_ea
);
	// restrictions grow with each lock bit the variant decodes: bit 0 only in single, bits 0-1 in two, all three in three
	always_comb
	begin
		block_table_read = 1'b0;
		block_program = 1'b0;
		block_verify = 1'b0;
		block_ext_exec = 1'b0;
		latch_ea = 1'b0;
		if (variant == lock_pkg::variant_single)
		begin
			block_verify = lock_bits[0];
			block_program = lock_bits[0];
			block_ext_exec = lock_bits[0];
			block_table_read = lock_bits[0];
		end
		else
		begin
			block_table_read = lock_bits[0];
			block_program = lock_bits[0];
			latch_ea = lock_bits[0];
			block_verify = lock_bits[0] & lock_bits[1];
			if (variant == lock_pkg::variant_three)
				block_ext_exec = &lock_bits;
		end
	end
endmodule // lock_decode

// ---- rtl/key_cipher.sv ----
// verify encryption: xnor of a code byte with a key byte
// assumes key byte is chosen by the caller
`timescale 1ns/1ps
module key_cipher
(
	input wire logic [7:0] code_byte,
	input wire logic [7:0] key_byte,
	output logic [7:0] verify_byte
);
	// erased key all ones leaves the code unchanged
	assign verify_byte = ~(code_byte ^ key_byte);
endmodule // key_cipher

// ---- rtl/program_memory_lock_encrypt.sv ----
// program memory lock and encrypted verify, apb slave
// assumes synchronous inputs on pclk; erase and programming via registers
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module program_memory_lock_encrypt
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_access_select,
	input wire logic [7:0] code_byte,
	output logic ea_latched_reg_out,
	output logic table_read_blocked,
	output logic program_blocked,
	output logic ext_exec_blocked
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] key_reg [0:63];
	logic [2:0] lock_reg;
	lock_pkg::variant_type variant_reg;
	logic [5:0] key_idx_reg;
	logic [5:0] key_wr_idx_reg;
	logic ea_latch_reg;
	logic ea_armed_reg;
	logic [7:0] verify_reg;
	logic blk_tr, blk_pg, blk_vf, blk_ex, latch_ea;
	logic [7:0] verify_byte;
	logic [5:0] key_last;
	logic wr_en, rd_en;

	// next key position, back to the first byte after the last one
	function automatic logic [5:0] wrap_next(input logic [5:0] idx, input logic [5:0] last);
		return (idx == last) ? 6'h00 : idx + 6'h01;
	endfunction

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign key_last = (variant_reg == lock_pkg::variant_three) ?
		lock_pkg::key_last_large : lock_pkg::key_last_small;

	lock_decode lock_decode_inst
	(
		.lock_bits(lock_reg),
		.variant(variant_reg),
		.block_table_read(blk_tr),
		.block_program(blk_pg),
		.block_verify(blk_vf),
		.block_ext_exec(blk_ex),
		.latch_ea(latch_ea)
	);

	key_cipher key_cipher_inst
	(
		.code_byte(code_byte),
		.key_byte(key_reg[key_idx_reg]),
		.verify_byte(verify_byte)
	);

	// ------------------------------------------------------------
	// key array and lock bits
	// ------------------------------------------------------------
	// erase restores all ones and unlocks; writes refused when locked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < lock_pkg::key_depth_large; i++)
				key_reg[i] <= lock_pkg::key_erased;
			lock_reg <= 3'h0;
			key_wr_idx_reg <= 6'h00;
		end
		else if (wr_en && paddr == lock_pkg::addr_ctrl && pwdata[lock_pkg::ctrl_erase_bit])
		begin
			for (int i = 0; i < lock_pkg::key_depth_large; i++)
				key_reg[i] <= lock_pkg::key_erased;
			lock_reg <= 3'h0;
			key_wr_idx_reg <= 6'h00;
		end
		else if (wr_en && !blk_pg)
		begin
			if (paddr == lock_pkg::addr_lock)
				lock_reg <= lock_reg | pwdata[2:0]; // bits only get programmed
			else if (paddr == lock_pkg::addr_key)
			begin
				key_reg[key_wr_idx_reg] <= key_reg[key_wr_idx_reg] & pwdata[7:0];
				key_wr_idx_reg <= wrap_next(key_wr_idx_reg, key_last);
			end
		end
	end

	// variant strap set by software, fixed while any lock bit is set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			variant_reg <= lock_pkg::variant_reset;
		else if (wr_en && paddr == lock_pkg::addr_variant && lock_reg == 3'h0)
			variant_reg <= lock_pkg::variant_type'(pwdata[1:0]);
	end

	// ------------------------------------------------------------
	// verify sequencing
	// ------------------------------------------------------------
	// index restarts on start, steps per verify read, wraps at depth
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			key_idx_reg <= 6'h00;
		else if (wr_en && paddr == lock_pkg::addr_ctrl && pwdata[lock_pkg::ctrl_verify_start_bit])
			key_idx_reg <= 6'h00;
		else if (rd_en && paddr == lock_pkg::addr_verify)
			key_idx_reg <= wrap_next(key_idx_reg, key_last);
	end

	// single-bit variant never encrypts
	always_comb
	begin
		if (blk_vf)
			verify_reg = 8'h00;
		else if (variant_reg == lock_pkg::variant_single)
			verify_reg = code_byte;
		else
			verify_reg = verify_byte;
	end

	// ------------------------------------------------------------
	// external access latch
	// ------------------------------------------------------------
	// captured on the first clock after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ea_armed_reg <= 1'b1;
			ea_latch_reg <= 1'b0;
		end
		else if (ea_armed_reg)
		begin
			ea_armed_reg <= 1'b0;
			ea_latch_reg <= external_access_select;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ea_latched_reg_out <= 1'b0;
			table_read_blocked <= 1'b0;
			program_blocked <= 1'b0;
			ext_exec_blocked <= 1'b0;
		end
		else
		begin
			ea_latched_reg_out <= latch_ea ? ea_latch_reg : external_access_select;
			table_read_blocked <= blk_tr;
			program_blocked <= blk_pg;
			ext_exec_blocked <= blk_ex;
		end
	end

	// ------------------------------------------------------------
	// apb slave, no wait states
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (psel && !penable)
		begin
			pready <= 1'b1;
			pslverr <= !(paddr == lock_pkg::addr_ctrl || paddr == lock_pkg::addr_lock ||
				paddr == lock_pkg::addr_key || paddr == lock_pkg::addr_verify ||
				paddr == lock_pkg::addr_status || paddr == lock_pkg::addr_variant);
			case (paddr)
				lock_pkg::addr_lock: prdata <= {29'h0, lock_reg};
				lock_pkg::addr_verify: prdata <= {24'h0, verify_reg};
				lock_pkg::addr_status: prdata <= {22'h0, key_idx_reg, blk_ex, blk_vf, blk_pg,
					blk_tr};
				lock_pkg::addr_variant: prdata <= {30'h0, variant_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // program_memory_lock_encrypt

// ---- verification/lock_monitor.sv ----
// assertions on the ports of the lock block
// assumes a bind onto the top module
`timescale 1ns/1ps
module lock_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic external_access_select,
	input wire logic ea_latched_reg_out,
	input wire logic table_read_blocked,
	input wire logic program_blocked,
	input wire logic ext_exec_blocked
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus answer timing
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	unmapped_error_a: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
		else $error("no pslverr");
	// protection levels
	table_with_program_a: assert property (program_blocked |-> table_read_blocked)
		else $error("table read open");
	ext_needs_program_a: assert property (ext_exec_blocked |-> program_blocked)
		else $error("level order");
	erase_unlocks_a: assert property (psel && penable && pwrite && paddr == 8'h00
		&& pwdata[0] |-> ##2 !program_blocked && !ext_exec_blocked)
		else $error("erase kept locks");
	status_mirror_a: assert property (pready && !pwrite && paddr == 8'h10
		&& $stable(program_blocked) && $stable(ext_exec_blocked)
		|-> {prdata[3], prdata[1], prdata[0]} ==
		{ext_exec_blocked, program_blocked, table_read_blocked})
		else $error("status mismatch");
	ea_follows_pin_a: assert property ($past(presetn) && !table_read_blocked
		|-> ea_latched_reg_out == external_access_select)
		else $error("pin not followed");
	// the pin is held at its reset level, so the latched copy must agree with it
	ea_latch_hold_a: assert property ($past(presetn) && table_read_blocked
		|-> ea_latched_reg_out == external_access_select)
		else $error("latched pin differs");
endmodule // lock_monitor

bind program_memory_lock_encrypt lock_monitor lock_monitor_inst (.*);

// ---- verification/programmer_model.sv ----
// programmer model: code bytes and access pin
// assumes the bench picks the code address
`timescale 1ns/1ps
module programmer_model
#(parameter logic ea_level = 1'h1)
(
	input wire logic pclk,
	input wire logic [5:0] code_addr,
	output logic [7:0] code_byte,
	output logic external_access_select
);
	// pulse schemes the programmer applies per byte; the block only sees the writes
	localparam int pulses_single = 1;
	localparam int pulse_ms_single = 50;
	localparam int pulses_fast = 25;
	localparam int pulse_us_fast = 100;
	// varied code bytes, never all ones
	always_ff @(posedge pclk)
		code_byte <= {code_addr, 2'h1} ^ 8'h5b;
	// pin kept at the level latched in reset
	assign external_access_select = ea_level;
endmodule // programmer_model

// ---- verification/program_memory_lock_encrypt_tb_top.sv ----
// bench for the lock block: apb tasks and checks
// assumes the programmer model and bound monitor
`timescale 1ns/1ps
module program_memory_lock_encrypt_tb_top;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, code_byte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [5:0] ca = 6'h00;
	logic pready, pslverr, eas, err;
	int fails = 0, compares = 0, n;
	always #12.5 pclk = ~pclk;
	program_memory_lock_encrypt program_memory_lock_encrypt_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.external_access_select(eas), .code_byte, .ea_latched_reg_out(),
		.table_read_blocked(), .program_blocked(), .ext_exec_blocked());
	programmer_model programmer_model_inst (.pclk, .code_addr(ca), .code_byte,
		.external_access_select(eas));
	function automatic logic [7:0] cb(input logic [5:0] a);
		return {a, 2'h1} ^ 8'h5b;
	endfunction
	function automatic logic [7:0] kb(input logic [5:0] i);
		return 8'h3c ^ {i, 2'h2};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one apb transfer, then one idle cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic vr(input logic [5:0] i, input logic [7:0] e);
		ca <= i;
		@(posedge pclk);
		xfer(1'h0, lock_pkg::addr_verify, 32'h0);
		chk(rd, {24'h0, e});
	endtask
	task automatic close_out();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#400us;
		fails++;
		close_out();
	end
	// test sequence
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		xfer(1'h0, lock_pkg::addr_variant, 32'h0);
		chk(rd, 32'h2);
		vr(6'h05, cb(6'h05));
		for (int v = 1; v <= 2; v++)
		begin
			n = (v == 2) ? 64 : 32;
			xfer(1'h1, lock_pkg::addr_ctrl, 32'h1);
			xfer(1'h1, lock_pkg::addr_variant, 32'(v));
			for (int i = 0; i < n; i++)
				xfer(1'h1, lock_pkg::addr_key, {24'h0, kb(6'(i))});
			xfer(1'h1, lock_pkg::addr_ctrl, 32'h2);
			for (int i = 0; i < n + 2; i++)
				vr(6'(i), ~(cb(6'(i)) ^ kb(6'(i % n))));
			xfer(1'h1, lock_pkg::addr_ctrl, 32'h2);
			vr(6'h07, ~(cb(6'h07) ^ kb(6'h00)));
		end
		for (int j = 0; j < 3; j++)
		begin
			xfer(1'h1, lock_pkg::addr_ctrl, 32'h1);
			xfer(1'h1, lock_pkg::addr_lock, 32'((2 << j) - 1));
			xfer(1'h1, lock_pkg::addr_lock, 32'h7);
			xfer(1'h0, lock_pkg::addr_lock, 32'h0);
			chk({29'h0, rd[2:0]}, 32'((2 << j) - 1));
			xfer(1'h1, lock_pkg::addr_key, 32'h0);
			xfer(1'h0, lock_pkg::addr_status, 32'h0);
			chk({28'h0, rd[3:0]}, {28'h0, j > 1, j > 0, 2'h3});
			xfer(1'h1, lock_pkg::addr_ctrl, 32'h2);
			vr(6'h03, (j > 0) ? 8'h00 : cb(6'h03));
		end
		xfer(1'h1, lock_pkg::addr_ctrl, 32'h1);
		xfer(1'h0, lock_pkg::addr_lock, 32'h0);
		chk(rd, 32'h0);
		xfer(1'h1, lock_pkg::addr_variant, 32'h0);
		xfer(1'h1, lock_pkg::addr_lock, 32'h1);
		vr(6'h09, 8'h00);
		xfer(1'h0, lock_pkg::addr_status, 32'h0);
		chk({30'h0, rd[3], rd[1]}, 32'h3);
		xfer(1'h1, lock_pkg::addr_ctrl, 32'h1);
		xfer(1'h0, lock_pkg::addr_status, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h0);
		xfer(1'h0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		close_out();
	end
endmodule // program_memory_lock_encrypt_tb_top
